// ==== common/dpc_defs.svh ====
// Constants of the dual programmable counter.
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

// ----------------------------------------------------------------------
// Clock source codes
// ----------------------------------------------------------------------
`define DPC_SRC_PULSE 2'b11
`define DPC_SRC_EXT   2'b10
`define DPC_SRC_INSTR 2'b01
`define DPC_SRC_INT   2'b00

// ----------------------------------------------------------------------
// Mode codes, top clock-select bit then frequency mode bit
// ----------------------------------------------------------------------
`define DPC_MODE_CODE_CNT  2'b00
`define DPC_MODE_CODE_PW   2'b10
`define DPC_MODE_CODE_FQ   2'b01
`define DPC_MODE_CODE_NONE 2'b11

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define DPC_CNT_W    16
`define DPC_BYTE_W   8
`define DPC_CNT_RST  16'h0000
`define DPC_CNT_ONE  17'h00001
`define DPC_CARRY_B  16
`define DPC_SEL_TOP  2

`endif

// ==== common/dpc_pkg.sv ====
// Types and helpers of the dual programmable counter.
package dpc_pkg;
`include "dpc_defs.svh"

  typedef enum logic [1:0] {
    DPC_MODE_CNT  = `DPC_MODE_CODE_CNT,
    DPC_MODE_PW   = `DPC_MODE_CODE_PW,
    DPC_MODE_FQ   = `DPC_MODE_CODE_FQ,
    DPC_MODE_NONE = `DPC_MODE_CODE_NONE
  } dpc_mode_e;

  typedef logic [`DPC_CNT_W-1:0] dpc_cnt_t;

  // Returns the incremented count with the overflow carry on top.
  function automatic logic [`DPC_CNT_W:0] dpc_step(input dpc_cnt_t v);
    return {1'b0, v} + `DPC_CNT_ONE;
  endfunction

endpackage

// ==== src/dpc_edge_sync.sv ====
// Two-flop synchroniser with optional inversion and edge detection.
`timescale 1ns/1ps
`default_nettype none
module dpc_edge_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin_in,
  input  wire logic invert,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_q;
  logic s2_q;
  logic prev_q;
  logic lvl;
  logic prev_lvl;

  // The inversion sits after the second flop so the first flop feeds only the second.
  // Both samples pass the same invert bit, so flipping it alone never makes an edge.
  assign lvl      = s2_q ^ invert;
  assign prev_lvl = prev_q ^ invert;
  assign level    = lvl;
  assign rise     = lvl & ~prev_lvl;
  assign fall     = ~lvl & prev_lvl;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      s1_q   <= pin_in;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

endmodule // dpc_edge_sync
`default_nettype wire

// ==== src/dpc_top.sv ====
// Dual 16-bit programmable counter with counter, pulse-width and frequency modes.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_defs.svh"

// Notes on behaviour
// - Clock source field picks pulse input, external, instruction cycle or internal.
// - Invert bit flips pulse input level, also when it is the count clock.
// - Select bit cleared makes counter A the working counter.
// - Overflow sets flag; request only with both enables set.
// - Writing counter B also writes counter A with the same value.
// - Counter A overflow reloads counter A from counter B, or from the gate preset in frequency mode.
// - Run bit starts counting; clearing it stops counter mode.
// - Counter mode interrupts on every overflow and keeps counting.
// - Pulse-width mode times how long the pulse input stays high.
// - Pulse falling edge stops A, clears run, raises flag.
// - Pulse-width overflow while high raises flag, reloads, keeps counting.
// - Frequency mode is frequency bit set with top select bit cleared.
// - Frequency mode overflow raises flag and clears run.
// - After frequency measurement counter B holds the pulse count.
// - Mode code: 00 counter, 10 pulse width, 01 frequency, 11 none.
// - Two 16-bit counters, each written as two bytes and read as one 16-bit word.
module dpc_top
  import dpc_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [`DPC_BYTE_W-1:0] wr_data,
  input  wire logic                   a_hi_wr,
  input  wire logic                   a_lo_wr,
  input  wire logic                   b_hi_wr,
  input  wire logic                   b_lo_wr,
  input  wire logic                   run_wr,
  input  wire logic                   run_wdata,
  input  wire logic [2:0]             clock_source_select,
  input  wire logic                   freq_mode_select,
  input  wire logic                   input_invert,
  input  wire logic                   working_counter_select,
  input  wire logic                   counter_irq_enable,
  input  wire logic                   global_irq_enable,
  input  wire logic                   irq_flag_clr,
  input  wire logic                   instr_cycle,
  input  wire logic                   internal_clock,
  input  wire logic                   external_clock,
  input  wire logic                   pulse_freq_input,
  output logic [`DPC_CNT_W-1:0]       counter_a,
  output logic [`DPC_CNT_W-1:0]       counter_b,
  output logic                        count_run,
  output logic                        counter_irq_flag,
  output logic                        counter_irq_req
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic pulse_lvl;
  logic pulse_rise;
  logic pulse_fall;
  logic ext_rise;
  logic int_rise;

  dpc_edge_sync u_pulse (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (pulse_freq_input),
    .invert  (input_invert),
    .level   (pulse_lvl),
    .rise    (pulse_rise),
    .fall    (pulse_fall)
  );

  dpc_edge_sync u_ext (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (external_clock),
    .invert  (1'b0),
    .level   (),
    .rise    (ext_rise),
    .fall    ()
  );

  dpc_edge_sync u_int (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (internal_clock),
    .invert  (1'b0),
    .level   (),
    .rise    (int_rise),
    .fall    ()
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dpc_cnt_t cnt_a_q;
  dpc_cnt_t cnt_a_d;
  dpc_cnt_t cnt_b_q;
  dpc_cnt_t cnt_b_d;
  dpc_cnt_t gate_q;
  dpc_cnt_t gate_d;
  logic     run_q;
  logic     run_d;
  logic     run_prev_q;
  logic     flag_q;
  logic     flag_d;
  logic     req_q;
  logic     req_d;

  dpc_mode_e            mode;
  logic                 tick;
  logic                 event_hit;
  logic [`DPC_CNT_W:0]  step_a;
  logic [`DPC_CNT_W:0]  step_b;

  // Mode is decoded from the top select bit and the frequency bit.
  assign mode   = dpc_mode_e'({clock_source_select[`DPC_SEL_TOP], freq_mode_select});
  assign step_a = dpc_step(cnt_a_q);
  assign step_b = dpc_step(cnt_b_q);

  // ----------------------------------------------------------------------
  // Count clock selection
  // ----------------------------------------------------------------------
  // A selected pin clock is used as a one-cycle tick on its rising edge (instr_cycle is taken directly as a level), so
  // a source faster than half the system clock is undercounted.
  always_comb begin
    case (clock_source_select[1:0])
      `DPC_SRC_PULSE: tick = pulse_rise;
      `DPC_SRC_EXT:   tick = ext_rise;
      `DPC_SRC_INSTR: tick = instr_cycle;
      `DPC_SRC_INT:   tick = int_rise;
      default:        tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Counter next state
  // ----------------------------------------------------------------------
  always_comb begin
    cnt_a_d   = cnt_a_q;
    cnt_b_d   = cnt_b_q;
    gate_d    = gate_q;
    run_d     = run_q;
    event_hit = 1'b0;

    case (mode)
      DPC_MODE_CNT: begin
        if (run_q && tick) begin
          if (!working_counter_select) begin
            if (step_a[`DPC_CARRY_B]) begin
              cnt_a_d   = cnt_b_q;
              event_hit = 1'b1;
            end else begin
              cnt_a_d = step_a[`DPC_CNT_W-1:0];
            end
          end else begin
            if (step_b[`DPC_CARRY_B]) begin
              cnt_b_d   = cnt_a_q;
              event_hit = 1'b1;
            end else begin
              cnt_b_d = step_b[`DPC_CNT_W-1:0];
            end
          end
        end
      end
      DPC_MODE_PW: begin
        if (run_q && tick && pulse_lvl) begin
          if (step_a[`DPC_CARRY_B]) begin
            cnt_a_d   = cnt_b_q;
            event_hit = 1'b1;
          end else begin
            cnt_a_d = step_a[`DPC_CNT_W-1:0];
          end
        end
        if (run_q && pulse_fall) begin
          cnt_a_d   = cnt_a_q;
          run_d     = 1'b0;
          event_hit = 1'b1;
        end
      end
      DPC_MODE_FQ: begin
        if (run_q && !run_prev_q) begin
          cnt_b_d = `DPC_CNT_RST;
        end else if (run_q && pulse_rise) begin
          cnt_b_d = step_b[`DPC_CNT_W-1:0];
        end
        if (run_q && tick) begin
          if (step_a[`DPC_CARRY_B]) begin
            // Counter B now holds the edge count, so the gate preset is reused.
            cnt_a_d   = gate_q;
            run_d     = 1'b0;
            event_hit = 1'b1;
          end else begin
            cnt_a_d = step_a[`DPC_CNT_W-1:0];
          end
        end
      end
      default: begin
      end
    endcase

    // Software writes take priority over counting in the same cycle.
    if (a_hi_wr) begin
      cnt_a_d[`DPC_CNT_W-1:`DPC_BYTE_W] = wr_data;
    end
    if (a_lo_wr) begin
      cnt_a_d[`DPC_BYTE_W-1:0] = wr_data;
    end
    if (b_hi_wr) begin
      cnt_b_d[`DPC_CNT_W-1:`DPC_BYTE_W] = wr_data;
      cnt_a_d[`DPC_CNT_W-1:`DPC_BYTE_W] = wr_data;
      gate_d[`DPC_CNT_W-1:`DPC_BYTE_W]  = wr_data;
    end
    if (b_lo_wr) begin
      cnt_b_d[`DPC_BYTE_W-1:0] = wr_data;
      cnt_a_d[`DPC_BYTE_W-1:0] = wr_data;
      gate_d[`DPC_BYTE_W-1:0]  = wr_data;
    end
    if (run_wr) begin
      run_d = run_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Flag and request next state
  // ----------------------------------------------------------------------
  always_comb begin
    // A new event in the clearing cycle keeps the flag set.
    flag_d = (flag_q & ~irq_flag_clr) | event_hit;
    req_d  = flag_d & counter_irq_enable & global_irq_enable;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a_q    <= `DPC_CNT_RST;
      cnt_b_q    <= `DPC_CNT_RST;
      gate_q     <= `DPC_CNT_RST;
      run_q      <= 1'b0;
      run_prev_q <= 1'b0;
      flag_q     <= 1'b0;
      req_q      <= 1'b0;
    end else begin
      cnt_a_q    <= cnt_a_d;
      cnt_b_q    <= cnt_b_d;
      gate_q     <= gate_d;
      run_q      <= run_d;
      run_prev_q <= run_q;
      flag_q     <= flag_d;
      req_q      <= req_d;
    end
  end

  assign counter_a        = cnt_a_q;
  assign counter_b        = cnt_b_q;
  assign count_run        = run_q;
  assign counter_irq_flag = flag_q;
  assign counter_irq_req  = req_q;

endmodule // dpc_top
`default_nettype wire

// ==== sim/dpc_top_asserts.sv ====
// Concurrent checks on the ports of the dual programmable counter.
`timescale 1ns/1ps
`default_nettype none
module dpc_top_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  wr_data,
  input wire logic        a_hi_wr,
  input wire logic        a_lo_wr,
  input wire logic        b_hi_wr,
  input wire logic        b_lo_wr,
  input wire logic        run_wr,
  input wire logic        run_wdata,
  input wire logic [2:0]  clock_source_select,
  input wire logic        freq_mode_select,
  input wire logic        working_counter_select,
  input wire logic        counter_irq_enable,
  input wire logic        global_irq_enable,
  input wire logic        irq_flag_clr,
  input wire logic [15:0] counter_a,
  input wire logic [15:0] counter_b,
  input wire logic        count_run,
  input wire logic        counter_irq_flag,
  input wire logic        counter_irq_req
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire no_wr = !(a_hi_wr | a_lo_wr | b_hi_wr | b_lo_wr);
  b_load_a_a: assert property (b_lo_wr && b_hi_wr && !a_hi_wr && !a_lo_wr |=>
    counter_a == counter_b && counter_b[7:0] == $past(wr_data)) else $error("b write miss");
  req_gate_a: assert property (counter_irq_req |-> counter_irq_flag &&
    $past(counter_irq_enable) && $past(global_irq_enable)) else $error("req gate");
  flag_hold_a: assert property ($fell(counter_irq_flag) |-> $past(irq_flag_clr))
    else $error("flag lost");
  run_write_a: assert property (run_wr |=> count_run == $past(run_wdata))
    else $error("run write");
  stop_hold_a: assert property (!count_run && no_wr && !working_counter_select |=>
    $stable(counter_a)) else $error("count while stopped");
  ovf_reload_a: assert property ((no_wr && !working_counter_select && !freq_mode_select
    && counter_a == 16'hffff) ##1 (counter_a != 16'hffff) |->
    counter_a == counter_b && counter_irq_flag) else $error("reload");
  none_freeze_a: assert property (clock_source_select[2] && freq_mode_select && no_wr
    |=> $stable(counter_a) && $stable(counter_b)) else $error("mode none counts");
  hw_stop_a: assert property ($fell(count_run) && !$past(run_wr) |->
    counter_irq_flag) else $error("stop without flag");
  cover property ($rose(counter_irq_req));
  cover property ($fell(count_run) && !$past(run_wr));
  cover property (count_run && clock_source_select[2] && $rose(counter_irq_flag));
endmodule // dpc_top_asserts
`default_nettype wire

// ==== sim/dpc_pulse_src.sv ====
// Far-side signal source: free-running square wave or one fixed pulse.
`timescale 1ns/1ps
`default_nettype none
module dpc_pulse_src (
  input  wire logic       clk_sys,
  input  wire logic       idle_lvl,
  input  wire logic       free_run,
  input  wire logic       shot,
  input  wire logic [7:0] half_per,
  output logic            pulse_freq_input
);
  // Pulse length is fixed so the expected width is known to the bench.
  // Leaving free-running mode returns the line to idle at once, so a later shot is never lost.
  logic [7:0] cnt_q = 8'h00;
  logic       act_q = 1'b0;
  logic       one_q = 1'b0;
  always_ff @(posedge clk_sys) begin
    if (shot && !one_q) begin
      one_q <= 1'b1;
      act_q <= 1'b1;
      cnt_q <= 8'h00;
    end else if (one_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q >= 8'h4f) begin
        one_q <= 1'b0;
        act_q <= 1'b0;
      end
    end else if (free_run) begin
      if (cnt_q >= half_per - 8'h01) begin
        act_q <= !act_q;
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end else begin
      act_q <= 1'b0;
      cnt_q <= 8'h00;
    end
  end
  assign pulse_freq_input = idle_lvl ^ act_q;
endmodule // dpc_pulse_src
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking testbench of the dual programmable counter.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dpc_pkg::*;
  logic clk_sys, rst_n, a_hi_wr, a_lo_wr, b_hi_wr, b_lo_wr, run_wr, run_wdata;
  logic freq_mode_select, input_invert, working_counter_select, counter_irq_enable;
  logic global_irq_enable, irq_flag_clr, instr_cycle, internal_clock, external_clock;
  logic pulse_freq_input, count_run, counter_irq_flag, counter_irq_req;
  logic idle_lvl, free_run, shot;
  logic [7:0]  wr_data, half_per;
  logic [2:0]  clock_source_select;
  logic [15:0] counter_a, counter_b, v;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  dpc_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wr_data(wr_data), .a_hi_wr(a_hi_wr),
    .a_lo_wr(a_lo_wr), .b_hi_wr(b_hi_wr), .b_lo_wr(b_lo_wr), .run_wr(run_wr),
    .run_wdata(run_wdata), .clock_source_select(clock_source_select),
    .freq_mode_select(freq_mode_select), .input_invert(input_invert),
    .working_counter_select(working_counter_select), .counter_irq_enable(counter_irq_enable),
    .global_irq_enable(global_irq_enable), .irq_flag_clr(irq_flag_clr),
    .instr_cycle(instr_cycle), .internal_clock(internal_clock), .external_clock(external_clock),
    .pulse_freq_input(pulse_freq_input), .counter_a(counter_a), .counter_b(counter_b),
    .count_run(count_run), .counter_irq_flag(counter_irq_flag),
    .counter_irq_req(counter_irq_req));
  dpc_pulse_src i_src (.clk_sys(clk_sys), .idle_lvl(idle_lvl), .free_run(free_run),
    .shot(shot), .half_per(half_per), .pulse_freq_input(pulse_freq_input));
  // ----------------------------------------------------------------
  // Clock, tick sources and timeout
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    internal_clock <= cyc[2];
    external_clock <= (cyc % 12) < 6;
    instr_cycle <= (cyc % 5) == 0;
    if (cyc > 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Which: 0 A low, 1 A high, 2 B low, 3 B high, 4 run, 5 flag clear.
  task automatic strobe(input int which, input logic [7:0] d);
    @(posedge clk_sys);
    wr_data <= d;
    run_wdata <= d[0];
    {irq_flag_clr, run_wr, b_hi_wr, b_lo_wr, a_hi_wr, a_lo_wr} <= 6'h01 << which;
    @(posedge clk_sys);
    {irq_flag_clr, run_wr, b_hi_wr, b_lo_wr, a_hi_wr, a_lo_wr} <= 6'h00;
    #1;
  endtask
  task automatic wr_b(input logic [15:0] d);
    strobe(2, d[7:0]);
    strobe(3, d[15:8]);
  endtask
  task automatic start(input logic [15:0] d);
    wr_b(d);
    strobe(5, 8'h00);
    strobe(4, 8'h01);
  endtask
  // Bounded wait for the flag, or for the run bit to drop when run0 is set.
  task automatic wait_for(input logic run0);
    int i;
    for (i = 0; i < 400; i++) begin
      if (run0 ? count_run === 1'b0 : counter_irq_flag === 1'b1) break;
      @(posedge clk_sys);
      #1;
    end
    chk({15'h0, i < 400}, 16'h1);
  endtask
  task automatic fire();
    @(posedge clk_sys) shot <= 1'b1;
    @(posedge clk_sys) shot <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {a_hi_wr, a_lo_wr, b_hi_wr, b_lo_wr, run_wr, run_wdata, irq_flag_clr} = 7'h00;
    {freq_mode_select, input_invert, working_counter_select, global_irq_enable} = 4'h0;
    {idle_lvl, free_run, shot} = 3'h0;
    counter_irq_enable = 1'b1;
    wr_data = 8'h00;
    half_per = 8'h04;
    clock_source_select = 3'h0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(counter_a, 16'h0000);
    chk(counter_b, 16'h0000);
    chk({13'h0, count_run, counter_irq_flag, counter_irq_req}, 16'h0000);
    strobe(1, 8'h12);
    strobe(0, 8'h34);
    chk(counter_a, 16'h1234);
    @(posedge clk_sys);
    wr_data <= 8'h5a;
    {b_hi_wr, b_lo_wr} <= 2'b11;
    @(posedge clk_sys);
    {b_hi_wr, b_lo_wr} <= 2'b00;
    #1 chk(counter_b, 16'h5a5a);
    chk(counter_a, 16'h5a5a);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      clock_source_select <= s[2:0];
      global_irq_enable <= s[0];
      free_run <= (s == 3);
      start(16'hfffc);
      chk(counter_a, 16'hfffc);
      wait_for(1'b0);
      chk({14'h0, count_run, counter_irq_flag}, 16'h0003);
      chk({15'h0, counter_irq_req}, {15'h0, s[0]});
      strobe(4, 8'h00);
      v = counter_a;
      repeat (40) @(posedge clk_sys);
      #1 chk(counter_a, v);
    end
    @(posedge clk_sys) clock_source_select <= 3'b100;
    free_run <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys) input_invert <= k[0];
      idle_lvl <= k[0];
      start(16'h0000);
      fire();
      wait_for(1'b1);
      chk({15'h0, counter_irq_flag}, 16'h0001);
      chk({15'h0, counter_a >= 9 && counter_a <= 11}, 16'h0001);
    end
    start(16'hfffe);
    fire();
    wait_for(1'b0);
    chk({15'h0, count_run}, 16'h0001);
    wait_for(1'b1);
    @(posedge clk_sys) clock_source_select <= 3'b000;
    freq_mode_select <= 1'b1;
    free_run <= 1'b1;
    half_per <= 8'h08;
    start(16'hfff0);
    wait_for(1'b1);
    chk({15'h0, counter_irq_flag}, 16'h0001);
    chk({15'h0, counter_b >= 7 && counter_b <= 9}, 16'h0001);
    chk(counter_a, 16'hfff0);
    @(posedge clk_sys) clock_source_select <= 3'b100;
    strobe(4, 8'h01);
    v = counter_b;
    repeat (40) @(posedge clk_sys);
    #1 chk(counter_a, 16'hfff0);
    chk(counter_b, v);
    strobe(4, 8'h00);
    @(posedge clk_sys) clock_source_select <= 3'b001;
    freq_mode_select <= 1'b0;
    working_counter_select <= 1'b1;
    wr_b(16'hfffd);
    strobe(1, 8'h12);
    strobe(0, 8'h34);
    strobe(5, 8'h00);
    strobe(4, 8'h01);
    wait_for(1'b0);
    chk(counter_b, 16'h1234);
    chk(counter_a, 16'h1234);
    report_and_stop();
  end
endmodule // testbench
bind dpc_top dpc_top_asserts i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .wr_data(wr_data),
  .a_hi_wr(a_hi_wr), .a_lo_wr(a_lo_wr), .b_hi_wr(b_hi_wr), .b_lo_wr(b_lo_wr),
  .run_wr(run_wr), .run_wdata(run_wdata), .clock_source_select(clock_source_select),
  .freq_mode_select(freq_mode_select), .working_counter_select(working_counter_select),
  .counter_irq_enable(counter_irq_enable), .global_irq_enable(global_irq_enable),
  .irq_flag_clr(irq_flag_clr), .counter_a(counter_a), .counter_b(counter_b),
  .count_run(count_run), .counter_irq_flag(counter_irq_flag),
  .counter_irq_req(counter_irq_req));
`default_nettype wire
